// ---- design/ptsr_pkg.sv ----
package ptsr_pkg;
   // Bus geometry defaults
   localparam int ADDR_W      = 10;
   localparam int LANES       = 4;
   localparam int LANE_W      = 9;
   // Pipeline and sleep timing, in clock cycles
   localparam int READ_LAT    = 2;
   localparam int WDATA_LAT   = 2;
   localparam int SLEEP_ENTER = 2;
   localparam int SLEEP_EXIT  = 2;
   localparam int BURST_LEN   = 4;
   // Host-side FIFO depth
   localparam int FIFO_DEPTH  = 4;
endpackage : ptsr_pkg

// ---- design/ptsr_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ptsr_if #(
   parameter int ADDR_W = ptsr_pkg::ADDR_W,
   parameter int LANES  = ptsr_pkg::LANES,
   parameter int LANE_W = ptsr_pkg::LANE_W
);
   logic [ADDR_W-1:0]       addr;
   logic                    advance_load;
   logic                    write_n;
   logic [LANES-1:0]        byte_lane_write_n;
   logic                    chip_select_low_first;
   logic                    chip_select_high;
   logic                    chip_select_low_second;
   logic                    clock_gate_n;
   logic                    output_drive_n;
   logic                    burst_order_select;
   logic                    sleep_request;
   logic [LANES*LANE_W-1:0] host_dq_out;
   logic                    host_dq_oe_n;
   logic [LANES*LANE_W-1:0] mem_dq_out;
   logic                    mem_dq_oe_n;
   logic [LANES*LANE_W-1:0] dq_in;

   // Shared bus resolution: the enabled driver wins, else both ends read ones
   assign dq_in = !mem_dq_oe_n ? mem_dq_out : (!host_dq_oe_n ? host_dq_out : '1);

   modport mem (
      input  addr, advance_load, write_n, byte_lane_write_n, chip_select_low_first,
             chip_select_high, chip_select_low_second, clock_gate_n, output_drive_n,
             burst_order_select, sleep_request, dq_in,
      output mem_dq_out, mem_dq_oe_n
   );
   modport host (
      output addr, advance_load, write_n, byte_lane_write_n, chip_select_low_first,
             chip_select_high, chip_select_low_second, clock_gate_n, output_drive_n,
             burst_order_select, sleep_request, host_dq_out, host_dq_oe_n,
      input  dq_in
   );
endinterface : ptsr_if
`default_nettype wire

// ---- design/ptsr_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module ptsr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = ptsr_pkg::FIFO_DEPTH
) (
   input  wire logic             i_clk_sys, // System clock
   input  wire logic             i_rst_n,   // Synchronous reset, low
   input  wire logic             i_valid,   // Write side valid
   output logic                  o_ready,   // Write side ready
   input  wire logic [WIDTH-1:0] i_data,    // Write data
   output logic                  o_valid,   // Read side valid
   input  wire logic             i_ready,   // Read side ready
   output logic      [WIDTH-1:0] o_data     // Head entry
);
   localparam int PW = $clog2(DEPTH);
   // Pointer wrap relies on a power-of-two depth
   if (WIDTH < 1 || DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("ptsr_fifo: DEPTH must be power of two");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [PW:0]      cnt_q;
   logic             push;
   logic             pop;

   // Honest flags from the occupancy count
   assign o_ready = (cnt_q != (PW+1)'(DEPTH));
   assign o_valid = (cnt_q != '0);
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;
   assign o_data  = mem_q[rd_q];

   // Storage writes need no reset
   always_ff @(posedge i_clk_sys) begin
      if (push) begin
         mem_q[wr_q] <= i_data;
      end
   end

   // Pointers and count
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + PW'(1);
         if (pop)  rd_q <= rd_q + PW'(1);
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : ptsr_fifo
`default_nettype wire

// ---- design/ptsr_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R01] Synchronous inputs sampled on rising edge
// [R02] Clock gate high freezes all state; the model keeps its sleep and order synchronisers and sleep count running
// [R03] Start needs gate, load, selects active
// [R04] Read data driven from second edge
// [R05] Data driven only while drive enable low
// [R06] Write data captured two cycles after command
// [R07] Byte lanes select bytes; all high aborts
// [R08] Advance continues burst, wraps after four
// [R09] Counter changes only low two bits
// [R10] Order select low: linear increment
// [R11] Order select high: start XOR count
// [R12] Sleep entered two cycles after request
// [R13] Resume two cycles after request drops
// [R14] Deselect; continue-deselect only after deselect
// [R15] Host loads fresh address after deselect
// [R16] Reads and writes back to back
// [R17] Burst write beats use sampled lanes
// [R18] Sleep ignores inputs, floats outputs
// [R19] Host idles around sleep transitions
// [R20] Pins undriven while write data captured
module ptsr_mem #(
   parameter int ADDR_W = ptsr_pkg::ADDR_W,
   parameter int LANES  = ptsr_pkg::LANES,
   parameter int LANE_W = ptsr_pkg::LANE_W
) (
   input  wire logic i_clk_sys, // System clock
   input  wire logic i_rst_n,   // Model reset only, device has no pin
   ptsr_if.mem       bus        // Memory side of the bus
);
   localparam int DW = LANES*LANE_W;
   // Refuse geometries and timings the pipeline was not built for
   if (ADDR_W < 3 || ADDR_W > 20 || !(LANES == 2 || LANES == 4)) begin : g_bad_geometry
      $error("ptsr_mem: unsupported geometry");
   end
   if (ptsr_pkg::WDATA_LAT != 2 || ptsr_pkg::READ_LAT != 2
       || ptsr_pkg::SLEEP_ENTER < 1 || ptsr_pkg::SLEEP_ENTER > 4
       || ptsr_pkg::SLEEP_EXIT < 1 || ptsr_pkg::SLEEP_EXIT > 4) begin : g_bad_timing
      $error("ptsr_mem: pipeline or sleep counts out of range");
   end

   typedef enum logic [1:0] {PTSR_IDLE, PTSR_READ, PTSR_WRITE} ptsr_op_e;

   // The array itself lives per lane, in g_lane
   // Asynchronous pins pass two flops first
   logic [1:0]        sleep_sync_q;
   logic [1:0]        order_sync_q;
   logic              sleep_req;
   logic              order_sel;
   // Sleep sequencing
   logic [1:0]        sleep_cnt_q;
   logic              asleep_q;
   logic              active;
   // Burst state
   ptsr_op_e          op_q;
   logic [ADDR_W-1:0] base_q;
   logic [1:0]        beat_q;
   logic              desel_q;
   // Late-late write pipeline, two stages
   logic [ADDR_W-1:0] wa_q [ptsr_pkg::WDATA_LAT];
   logic [LANES-1:0]  wl_q [ptsr_pkg::WDATA_LAT];
   logic [ptsr_pkg::WDATA_LAT-1:0] wv_q;
   // Read pipeline
   logic [DW-1:0]     rd_data_q;
   logic              rd_v1_q;
   logic              rd_v2_q;
   logic [DW-1:0]     out_q;
   logic [ADDR_W-1:0] rd_addr_q;
   logic [DW-1:0]     fetch_word;
   logic [DW-1:0]     late_word;
   // Decode
   logic              enabled;
   logic              selected;
   logic              start;
   logic              cont;
   logic [1:0]        next_beat;
   logic [1:0]        low_bits;
   logic [ADDR_W-1:0] beat_addr;
   logic              beat_read;
   logic              beat_write;

   // Synchronisers for the asynchronous controls
   always_ff @(posedge i_clk_sys) begin // see [R01]
      if (!i_rst_n) begin
         sleep_sync_q <= '0;
         order_sync_q <= '0;
      end else begin
         sleep_sync_q <= {sleep_sync_q[0], bus.sleep_request};
         order_sync_q <= {order_sync_q[0], bus.burst_order_select};
      end
   end
   assign sleep_req = sleep_sync_q[1];
   assign order_sel = order_sync_q[1];

   // Sleep entry and exit each take two cycles; state is kept throughout
   always_ff @(posedge i_clk_sys) begin // see [R12] see [R13]
      if (!i_rst_n) begin
         sleep_cnt_q <= '0;
         asleep_q    <= 1'b0;
      end else if (sleep_req != asleep_q) begin
         // Entry and exit each wait their own count
         if (sleep_cnt_q == (asleep_q ? 2'(ptsr_pkg::SLEEP_EXIT - 1)
                                      : 2'(ptsr_pkg::SLEEP_ENTER - 1))) begin
            asleep_q    <= sleep_req;
            sleep_cnt_q <= '0;
         end else begin
            sleep_cnt_q <= sleep_cnt_q + 2'h1;
         end
      end else begin
         sleep_cnt_q <= '0;
      end
   end
   // Asleep ignores every input but the sleep request
   assign active   = !asleep_q;                                  // see [R18]
   assign enabled  = active && !bus.clock_gate_n;                // see [R02]
   assign selected = !bus.chip_select_low_first && bus.chip_select_high
                     && !bus.chip_select_low_second;
   assign start    = enabled && !bus.advance_load && selected;    // see [R03]
   // Advance after a deselect keeps the device deselected
   assign cont      = enabled && bus.advance_load && !desel_q;    // see [R14]
   assign next_beat = beat_q + 2'h1;                              // see [R08]
   // Interleaved XORs beat count into the start bits, linear adds
   assign low_bits  = order_sel ? (base_q[1:0] ^ next_beat)       // see [R11]
                                : (base_q[1:0] + next_beat);      // see [R10]
   assign beat_addr = start ? bus.addr : {base_q[ADDR_W-1:2], low_bits}; // see [R09]
   assign beat_read  = (start && bus.write_n) || (cont && op_q == PTSR_READ);
   assign beat_write = (start && !bus.write_n) || (cont && op_q == PTSR_WRITE);

   // Burst tracking; a frozen edge leaves it untouched
   always_ff @(posedge i_clk_sys) begin // see [R02]
      if (!i_rst_n) begin
         op_q    <= PTSR_IDLE;
         base_q  <= '0;
         beat_q  <= '0;
         desel_q <= 1'b1;
      end else if (enabled) begin
         if (start) begin // see [R16]
            op_q    <= bus.write_n ? PTSR_READ : PTSR_WRITE;
            base_q  <= bus.addr;
            beat_q  <= '0;
            desel_q <= 1'b0;
         end else if (!bus.advance_load) begin
            op_q    <= PTSR_IDLE; // see [R14]
            desel_q <= 1'b1;
         end else if (cont) begin
            beat_q <= next_beat; // see [R08]
         end
      end
   end

   // Write address and lanes wait two cycles for their data
   always_ff @(posedge i_clk_sys) begin // see [R06] see [R17]
      if (!i_rst_n) begin
         wv_q <= '0;
      end else if (enabled) begin
         wv_q <= {wv_q[0], beat_write};
      end
   end
   always_ff @(posedge i_clk_sys) begin
      if (enabled) begin
         wa_q[0] <= beat_addr;
         wl_q[0] <= bus.byte_lane_write_n;
         wa_q[1] <= wa_q[0];
         wl_q[1] <= wl_q[0];
      end
   end

   // Capture write data per lane; all lanes high aborts the beat
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      logic [LANE_W-1:0] store_q [2**ADDR_W];
      logic              land_now;
      logic              land_late;
      // A write landing now at the fetched or held read address
      assign land_now  = wv_q[1] && !wl_q[1][l] && (wa_q[1] == beat_addr);
      assign land_late = wv_q[1] && !wl_q[1][l] && (wa_q[1] == rd_addr_q);
      always_ff @(posedge i_clk_sys) begin // see [R07]
         if (enabled && wv_q[1] && !wl_q[1][l]) begin
            store_q[wa_q[1]] <= bus.dq_in[l*LANE_W +: LANE_W];
         end
      end
      // Forwarding keeps reads coherent with writes still in the late-write pipe
      assign fetch_word[l*LANE_W +: LANE_W] = land_now ? bus.dq_in[l*LANE_W +: LANE_W]
                                                       : store_q[beat_addr];
      assign late_word[l*LANE_W +: LANE_W]  = land_late ? bus.dq_in[l*LANE_W +: LANE_W]
                                                        : rd_data_q[l*LANE_W +: LANE_W];
   end

   // Array fetched after the first edge, driven from the second
   always_ff @(posedge i_clk_sys) begin // see [R04]
      if (!i_rst_n) begin
         rd_v1_q <= 1'b0;
         rd_v2_q <= 1'b0;
      end else if (enabled) begin
         rd_v1_q <= beat_read;
         rd_v2_q <= rd_v1_q;
      end else if (asleep_q) begin
         rd_v2_q <= 1'b0;
      end
   end
   always_ff @(posedge i_clk_sys) begin
      if (enabled) begin
         rd_data_q <= fetch_word;
         rd_addr_q <= beat_addr;
         out_q     <= late_word;
      end
   end

   // Drive only for a read beat; writes leave the pins to the host
   assign bus.mem_dq_out  = out_q;
   assign bus.mem_dq_oe_n = !(rd_v2_q && active && !bus.output_drive_n); // see [R05] see [R20]
endmodule : ptsr_mem
`default_nettype wire

// ---- design/ptsr_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module ptsr_host #(
   parameter int ADDR_W = ptsr_pkg::ADDR_W,
   parameter int LANES  = ptsr_pkg::LANES,
   parameter int LANE_W = ptsr_pkg::LANE_W
) (
   input  wire logic                    i_clk_sys,   // System clock
   input  wire logic                    i_rst_n,     // Synchronous reset, low
   input  wire logic                    i_req_valid, // Command valid
   output logic                         o_req_ready, // FIFO has room
   input  wire logic                    i_req_write, // 1 write, 0 read
   input  wire logic                    i_req_burst, // 1 four-beat continue
   input  wire logic [ADDR_W-1:0]       i_req_addr,  // Address
   input  wire logic [LANES-1:0]        i_req_lanes_n, // Lane enables, low
   input  wire logic [LANES*LANE_W-1:0] i_req_wdata, // Write data
   input  wire logic                    i_order,     // Burst order level
   input  wire logic                    i_sleep,     // Sleep request level
   output logic                         o_rd_valid,  // Read beat pulse
   output logic      [LANES*LANE_W-1:0] o_rd_data,   // Read data
   ptsr_if.host                         bus          // Host side of the bus
);
   localparam int DW = LANES*LANE_W;
   localparam int CW = 2 + ADDR_W + LANES + DW;
   // Memory side: two sync flops, its exit count, one cycle of margin
   localparam int WAKE = 2 + ptsr_pkg::SLEEP_EXIT + 1;
   if (LANES != 2 && LANES != 4) begin : g_bad_lanes
      $error("ptsr_host: LANES must be 2 or 4");
   end
   if (WAKE > 7) begin : g_bad_wake
      $error("ptsr_host: wake-up wait does not fit its counter");
   end

   logic          f_valid;
   logic          f_ready;
   logic [CW-1:0] f_data;
   logic          f_write;
   logic          f_burst;
   logic [DW-1:0] f_wdata;
   logic          issue;
   logic          desel_q;
   logic [2:0]    wv_q;
   logic [DW-1:0] wd_q [2];
   logic [2:0]    rv_q;
   logic          wait_n;
   logic [2:0]    wake_q;

   // Command queue; the bus drains it one beat per cycle
   ptsr_fifo #(.WIDTH(CW), .DEPTH(ptsr_pkg::FIFO_DEPTH)) u_fifo (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_valid   (i_req_valid),
      .o_ready   (o_req_ready),
      .i_data    ({i_req_write, i_req_burst, i_req_addr, i_req_lanes_n, i_req_wdata}),
      .o_valid   (f_valid),
      .i_ready   (f_ready),
      .o_data    (f_data)
   );
   assign f_write = f_data[CW-1];
   assign f_burst = f_data[CW-2];
   assign f_wdata = f_data[DW-1:0];
   // Stall while sleep is requested and until the memory is awake again
   assign wait_n  = !i_sleep && (wake_q == 3'h0); // see [R19]
   // A continuation after a deselect is held back, never issued
   assign f_ready = wait_n && !(f_burst && desel_q); // see [R15]
   assign issue   = f_valid && f_ready;

   // Without this wait, queued reads would reach a still sleeping memory
   always_ff @(posedge i_clk_sys) begin // see [R19]
      if (!i_rst_n) begin
         wake_q <= 3'h0;
      end else if (i_sleep) begin
         wake_q <= 3'(WAKE);
      end else if (wake_q != 3'h0) begin
         wake_q <= wake_q - 3'h1;
      end
   end

   // Command pins
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         bus.addr                  <= '0;
         bus.advance_load          <= 1'b0;
         bus.write_n               <= 1'b1;
         bus.byte_lane_write_n     <= '1;
         bus.chip_select_low_first <= 1'b1;
         desel_q                   <= 1'b1;
      end else begin
         bus.addr                  <= f_data[CW-3 -: ADDR_W];
         bus.write_n               <= !(issue && f_write);
         bus.byte_lane_write_n     <= issue ? f_data[DW +: LANES] : '1;
         bus.advance_load          <= issue && f_burst;
         bus.chip_select_low_first <= !issue;
         desel_q                   <= !issue;
      end
   end
   assign bus.chip_select_high       = 1'b1;
   assign bus.chip_select_low_second = 1'b0;
   assign bus.clock_gate_n           = 1'b0;
   assign bus.output_drive_n         = 1'b0;
   assign bus.burst_order_select     = i_order;
   assign bus.sleep_request          = i_sleep;

   // Write data two cycles behind the command
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         wv_q <= '0;
         rv_q <= '0;
      end else begin
         wv_q <= {wv_q[1:0], issue && f_write};
         rv_q <= {rv_q[1:0], issue && !f_write};
      end
   end
   always_ff @(posedge i_clk_sys) begin
      wd_q[0]         <= f_wdata;
      wd_q[1]         <= wd_q[0];
      bus.host_dq_out <= wd_q[1];
   end
   assign bus.host_dq_oe_n = !wv_q[2];

   // Read data valid on the pins two edges after the command edge
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_rd_valid <= 1'b0;
         o_rd_data  <= '0;
      end else begin
         o_rd_valid <= rv_q[2];
         o_rd_data  <= bus.dq_in;
      end
   end
endmodule : ptsr_host
`default_nettype wire

// ---- test/ptsr_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module ptsr_asserts (
   input  wire logic i_clk_sys,              // System clock
   input  wire logic i_rst_n,                // Sync reset, low
   input  wire logic clock_gate_n,           // Clock gate, low runs
   input  wire logic advance_load,           // Burst advance
   input  wire logic write_n,                // Write when low
   input  wire logic chip_select_low_first,  // Select, low
   input  wire logic chip_select_high,       // Select, high
   input  wire logic chip_select_low_second, // Select, low
   input  wire logic output_drive_n,         // Drive enable, low
   input  wire logic sleep_request,          // Sleep level
   input  wire logic host_dq_oe_n,           // Host drives when low
   input  wire logic mem_dq_oe_n             // Memory drives when low
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   logic [3:0] quiet_q;
   logic       start;
   logic       awake;
   // Start condition: gate, load and all selects active
   assign start = !clock_gate_n && !advance_load && !chip_select_low_first
                  && chip_select_high && !chip_select_low_second;
   // Settled well past the sleep syncs and wake-up count
   assign awake = quiet_q >= 4'h8;
   // Cycles since sleep was last requested
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || sleep_request) quiet_q <= 4'h0;
      else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
   end
   property p_rd_lat;
      start && write_n && awake |-> ##2 (output_drive_n || !mem_dq_oe_n);
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read data late");
   property p_drive;
      !mem_dq_oe_n |-> !output_drive_n;
   endproperty
   a_drive: assert property (p_drive) else $error("drive without enable");
   property p_desel;
      !clock_gate_n && !advance_load && (chip_select_low_first || !chip_select_high
         || chip_select_low_second) |-> ##2 mem_dq_oe_n;
   endproperty
   a_desel: assert property (p_desel) else $error("drive after deselect");
   property p_wr_float;
      start && !write_n && awake |-> ##2 (mem_dq_oe_n && !host_dq_oe_n);
   endproperty
   a_wr_float: assert property (p_wr_float) else $error("write data slot");
   property p_no_turn;
      start && write_n && awake ##1 start && !write_n
         |-> ##1 (output_drive_n || !mem_dq_oe_n) ##1 (mem_dq_oe_n && !host_dq_oe_n);
   endproperty
   a_no_turn: assert property (p_no_turn) else $error("turnaround seen");
   property p_burst_rd;
      start && write_n && awake ##1 (advance_load && !clock_gate_n)
         |-> ##2 (output_drive_n || !mem_dq_oe_n);
   endproperty
   a_burst_rd: assert property (p_burst_rd) else $error("burst read beat lost");
   property p_burst_wr;
      start && !write_n && awake ##1 (advance_load && !clock_gate_n)
         |-> ##2 (mem_dq_oe_n && !host_dq_oe_n);
   endproperty
   a_burst_wr: assert property (p_burst_wr) else $error("burst write slot");
   property p_sleep;
      sleep_request [*5] |-> mem_dq_oe_n;
   endproperty
   a_sleep: assert property (p_sleep) else $error("drive while asleep");
   c_read:  cover property (start && write_n ##2 !mem_dq_oe_n);
   c_write: cover property (start && !write_n ##2 !host_dq_oe_n);
   c_burst: cover property (start ##1 advance_load [*3]);
   c_sleep: cover property (sleep_request [*8]);
endmodule // ptsr_asserts
`default_nettype wire

// ---- test/tb_pipelined_no_turnaround_sram.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_pipelined_no_turnaround_sram;
   localparam int AW = ptsr_pkg::ADDR_W;
   localparam int LN = ptsr_pkg::LANES;
   localparam int LW = ptsr_pkg::LANE_W;
   localparam int DW = LN*LW;
   logic          i_clk_sys = 1'b0;
   logic          i_rst_n   = 1'b0;
   logic          req_valid = 1'b0;
   logic          req_ready;
   logic          req_write = 1'b0;
   logic          req_burst = 1'b0;
   logic [AW-1:0] req_addr  = '0;
   logic [LN-1:0] req_lanes = '1;
   logic [DW-1:0] req_wdata = '0;
   logic          order     = 1'b0;
   logic          sleep     = 1'b0;
   logic          rd_valid;
   logic [DW-1:0] rd_data;
   logic [DW-1:0] model_q [2**AW];
   logic [DW-1:0] exp_q [$];
   logic [AW-1:0] start_a;
   logic [31:0]   seed = 32'h0000003A;
   logic [31:0]   r;
   int            beat, n_errors, checks_done, rd_beats, oe_beats;

   ptsr_if ptsr_if_i ();
   ptsr_host ptsr_host_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req_valid(req_valid),
      .o_req_ready(req_ready), .i_req_write(req_write), .i_req_burst(req_burst),
      .i_req_addr(req_addr), .i_req_lanes_n(req_lanes), .i_req_wdata(req_wdata),
      .i_order(order), .i_sleep(sleep), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
      .bus(ptsr_if_i));
   ptsr_mem ptsr_mem_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .bus(ptsr_if_i));
   ptsr_asserts ptsr_asserts_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
      .clock_gate_n(ptsr_if_i.clock_gate_n), .advance_load(ptsr_if_i.advance_load),
      .write_n(ptsr_if_i.write_n), .chip_select_low_first(ptsr_if_i.chip_select_low_first),
      .chip_select_high(ptsr_if_i.chip_select_high),
      .chip_select_low_second(ptsr_if_i.chip_select_low_second),
      .output_drive_n(ptsr_if_i.output_drive_n), .sleep_request(ptsr_if_i.sleep_request),
      .host_dq_oe_n(ptsr_if_i.host_dq_oe_n), .mem_dq_oe_n(ptsr_if_i.mem_dq_oe_n));

   // Free-running 20 MHz clock
   initial begin
      forever #25 i_clk_sys = ~i_clk_sys;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [DW-1:0] rdw();
      logic [63:0] v;
      v = {rnd(), rnd()};
      return v[DW-1:0];
   endfunction

   task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic idle(input int n);
      req_valid = 1'b0;
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask

   // Beat address: low two bits counted from the start, the rest held
   function automatic logic [AW-1:0] burst_beat_addr(input logic [AW-1:0] s, input int k,
                                                       input logic il);
      logic [1:0] kb;
      kb = k[1:0];
      if (il) return {s[AW-1:2], s[1:0] ^ kb};
      return {s[AW-1:2], s[1:0] + kb};
   endfunction

   // One beat; the model applies it in issue order and predicts the address
   task automatic send(input logic w, input logic b, input logic [AW-1:0] a,
                       input logic [LN-1:0] ln, input logic [DW-1:0] d);
      logic [AW-1:0] ea;
      int            n;
      if (b) begin
         beat = beat + 1;
         ea = burst_beat_addr(start_a, beat, order);
      end else begin
         beat = 0;
         start_a = a;
         ea = a;
      end
      if (w) begin
         for (int l = 0; l < LN; l++) if (!ln[l]) model_q[ea][l*LW +: LW] = d[l*LW +: LW];
      end else begin
         exp_q.push_back(model_q[ea]);
         rd_beats++;
      end
      {req_valid, req_write, req_burst, req_addr, req_lanes, req_wdata} = {1'b1, w, b, a, ln, d};
      n = 0;
      while (req_ready !== 1'b1 && n < 400) begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end
      @(posedge i_clk_sys);
      #1;
   endtask

   // Four beats; continuation addresses are junk so only the counter counts
   task automatic burst(input logic w, input logic [AW-1:0] a, input logic abort2);
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         send(w, k != 0, k != 0 ? r[AW+3:4] : a, (abort2 && k == 2) ? '1 : r[3:0], rdw());
      end
   endtask

   // Read returns and data-pin drive cycles
   always @(posedge i_clk_sys) begin
      if (ptsr_if_i.mem_dq_oe_n === 1'b0) oe_beats++;
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) check("unexpected read", 1'b1, 1'b0);
         else check("read data", rd_data, exp_q.pop_front());
      end
   end

   // Hang guard: the run needs about 3,000 cycles, so 10,000 means a stall
   initial begin
      repeat (10_000) @(posedge i_clk_sys);
      n_errors++;
      give_verdict();
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge i_clk_sys);
      #1;
      i_rst_n = 1'b1;
      @(posedge i_clk_sys);
      #1;
      for (int a = 0; a < 2**AW; a++) send(1'b1, 1'b0, a[AW-1:0], '0, rdw());
      for (int o = 0; o < 2; o++) begin
         idle(8);
         order = o[0];
         idle(8);
         for (int s = 0; s < 4; s++) begin
            r = rnd();
            burst(1'b1, {r[AW-1:2], s[1:0]}, 1'b1);
            burst(1'b0, {r[AW-1:2], s[1:0]}, 1'b0);
         end
         for (int k = 0; k < 300; k++) begin
            r = rnd();
            if (r[0]) burst(r[1], r[AW+1:2], 1'b0);
            else send(r[1], 1'b0, r[AW+1:2], r[15:12], rdw());
         end
      end
      // Sleep stalls the host, so its FIFO fills and refuses
      idle(8);
      sleep = 1'b1;
      idle(10);
      check("float asleep", ptsr_if_i.mem_dq_oe_n, 1'b1);
      for (int k = 0; k < ptsr_pkg::FIFO_DEPTH; k++) send(1'b0, 1'b0, AW'(rnd()), '1, '0);
      check("fifo full", req_ready, 1'b0);
      idle(4);
      sleep = 1'b0;
      idle(12);
      for (int k = 0; k < 20; k++) send(1'b0, 1'b0, AW'(rnd()), '1, '0);
      idle(30);
      check("reads left", exp_q.size(), 0);
      check("drive cycles", oe_beats, rd_beats);
      give_verdict();
   end
endmodule // tb_pipelined_no_turnaround_sram
`default_nettype wire
